// file: dv/harvester_power_state_controller_tb.sv
`timescale 1ns/1ps
module harvester_power_state_controller_tb;
  import hpsc_pkg::*;
  localparam int PR = 20;
  localparam int PO = 8;
  localparam int QU = 4;
  localparam int CR = 16;
  logic core_clk = 1'b0, rst_b = 1'b0, internal_supply_rail_ok = 1'b1, internal_supply_rail_cold_ok = 1'b0;
  logic sto_gt_ovdis = 1'b1, sto_gt_chrdy = 1'b0, sto_ge_ovch = 1'b0, sto_gt_buck_ovdis = 1'b1;
  logic sto_gt_buck_rdy = 1'b1, aux_charging = 1'b0, temp_in_range = 1'b1, temp_dis_ok = 1'b1;
  logic src_above_low = 1'b1, mpp_above_low = 1'b1, shipping_hold_pin = 1'b0;
  logic [CFG_W-1:0] cfg_pins = 8'h5a;
  logic reg_wr, reg_rd, sda_level, scl_level, host_msg_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] op_state;
  logic boost_en, aux_charge_allow, buck_en, load_status_pin, internal_supply_rail_from_sto, battery_node_hiz;
  logic i2c_enabled, notify_pin, reg_config_mode, monitor_update_en;
  logic [CFG_W-1:0] cfg_sampled;
  int miscompares = 0, n_tests = 0, cyc = 0;
  hpsc_ctrl #(.PROBE_CYCLES(PR), .POLL_CYCLES(PO), .QUAL_CYCLES(QU), .CRIT_CYCLES(CR)) i_dut (
    .core_clk, .rst_b, .internal_supply_rail_ok, .internal_supply_rail_cold_ok, .sto_gt_ovdis, .sto_gt_chrdy, .sto_ge_ovch,
    .sto_gt_buck_ovdis, .sto_gt_buck_rdy, .aux_charging, .temp_in_range, .temp_dis_ok,
    .src_above_low, .mpp_above_low, .shipping_hold_pin, .sda_level, .scl_level, .host_msg_seen,
    .cfg_pins, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .op_state, .boost_en,
    .aux_charge_allow, .buck_en, .load_status_pin, .internal_supply_rail_from_sto, .battery_node_hiz,
    .i2c_enabled, .notify_pin, .reg_config_mode, .monitor_update_en, .cfg_sampled);
  hpsc_host i_host (.core_clk, .reg_rdata, .notify_pin, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .sda_level, .scl_level, .host_msg_seen);
  // clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // wait bounded for a state
  task automatic wait_st(input hpsc_state_e s, input int lim);
    for (int i = 0; i < lim && op_state !== s; i++) @(posedge core_clk) #1;
    chk("op_state", 8'(s), 8'(op_state));
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("reg_rdata", exp, d);
  endtask
  // reset values and cold start into start
  task automatic t_cold();
    repeat (5) @(posedge core_clk);
    #1 chk("state", 8'(ST_RESET), 8'(op_state));
    chk("hiz_boost_buck_notify", 8'h08, {battery_node_hiz, boost_en, buck_en, notify_pin});
    rdchk(ADDR_CTRL, 8'h0e);
    rdchk(8'h05, 8'h00);
    @(posedge core_clk) internal_supply_rail_cold_ok <= 1'b1;
    wait_st(ST_PROBE, 6);
    chk("cfg_sampled", 8'h5a, cfg_sampled);
    repeat (PR - 4) @(posedge core_clk);
    #1 chk("probe_hold", 8'h10, {4'(op_state), 2'b0, boost_en, buck_en});
    wait_st(ST_START, 8);
    chk("start_out", 8'h0b, {internal_supply_rail_from_sto, buck_en, i2c_enabled, notify_pin});
    rdchk(ADDR_EVT, 8'h01);
    chk("notify_clr", 8'h00, 8'(notify_pin));
    chk("monitor", 8'h00, 8'(monitor_update_en));
    @(posedge core_clk) cfg_pins <= 8'h33;
    repeat (PO + 4) @(posedge core_clk);
    #1 chk("cfg_poll", 8'h33, cfg_sampled);
  endtask
  // supply, buck gating, register takeover, sleep
  task automatic t_supply();
    @(posedge core_clk) sto_gt_chrdy <= 1'b1;
    wait_st(ST_SUPPLY, 6);
    repeat (3) @(posedge core_clk);
    #1 chk("buck_on", 8'h03, {buck_en, load_status_pin});
    @(posedge core_clk) temp_dis_ok <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("buck_hot", 8'h00, {buck_en, load_status_pin});
    // aux charging: boosts stop, buck judged against the lower level
    @(posedge core_clk) temp_dis_ok <= 1'b1;
    aux_charging <= 1'b1;
    sto_gt_buck_rdy <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("aux_chg", 8'h01, {boost_en, buck_en});
    @(posedge core_clk) aux_charging <= 1'b0;
    sto_gt_buck_rdy <= 1'b1;
    i_host.configure(8'h0f);
    cfg_pins <= 8'h00;
    repeat (PO + 4) @(posedge core_clk);
    #1 chk("cfg_kept", 8'h33, cfg_sampled);
    chk("reg_mode", 8'h07, {reg_config_mode, monitor_update_en, buck_en});
    @(posedge core_clk) sto_ge_ovch <= 1'b1;
    wait_st(ST_SLEEP, 6);
    chk("sleep_out", 8'h0a, {internal_supply_rail_from_sto, boost_en, buck_en, aux_charge_allow});
    @(posedge core_clk) sto_ge_ovch <= 1'b0;
    wait_st(ST_SUPPLY, 6);
    i_host.wr(ADDR_CTRL, 8'h03);
    wait_st(ST_SLEEP, 6);
    repeat (4) @(posedge core_clk);
    #1 chk("stay_sleep", 8'(ST_SLEEP), 8'(op_state));
    i_host.wr(ADDR_CTRL, 8'h0f);
    wait_st(ST_SUPPLY, 6);
  endtask
  // qualified low storage, recovery does not cancel
  task automatic t_deep();
    @(posedge core_clk) sto_gt_ovdis <= 1'b0;
    repeat (QU + 5) @(posedge core_clk);
    sto_gt_ovdis <= 1'b1;
    wait_st(ST_DEEP, CR + 8);
    chk("deep_out", 8'h01, {internal_supply_rail_from_sto, buck_en, aux_charge_allow});
    wait_st(ST_START, 6);
    wait_st(ST_SUPPLY, 6);
  endtask
  // shipping hold, serial port wake, rail loss
  task automatic t_ship();
    @(posedge core_clk) shipping_hold_pin <= 1'b1;
    wait_st(ST_RESET, PO + 6);
    chk("ship_out", 8'h04, {battery_node_hiz, boost_en, notify_pin});
    i_host.lines(1'b0);
    shipping_hold_pin <= 1'b0;
    wait_st(ST_PROBE, PO + 6);
    repeat (PR + 6) @(posedge core_clk);
    #1 chk("i2c_off", 8'h00, {i2c_enabled, notify_pin});
    i_host.lines(1'b1);
    i_host.send_msg();
    repeat (2) @(posedge core_clk);
    #1 chk("i2c_wake", 8'h03, {i2c_enabled, notify_pin});
    rdchk(ADDR_EVT, 8'h01);
    rdchk(ADDR_CTRL, 8'h0f);
    @(posedge core_clk) internal_supply_rail_ok <= 1'b0;
    wait_st(ST_RESET, 6);
    rdchk(ADDR_CTRL, 8'h0e);
    chk("loss_hiz", 8'h01, 8'(battery_node_hiz));
  endtask
  // verdict
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    t_cold();
    t_supply();
    t_deep();
    t_ship();
    final_report();
  end
endmodule // harvester_power_state_controller_tb

// file: dv/hpsc_host.sv
`timescale 1ns/1ps
module hpsc_host (
  // clock and device answers
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic notify_pin,
  // register port and serial line levels
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic sda_level,
  output logic scl_level,
  output logic host_msg_seen
);
  // idle: strobes low, lines pulled high
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sda_level = 1'b1;
    scl_level = 1'b1;
    host_msg_seen = 1'b0;
  end
  // one write, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data never looks valid
  endtask
  // one read, data registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // wait for notify before configuring, then apply
  task automatic configure(input logic [7:0] d);
    int i;
    for (i = 0; i < 50 && notify_pin !== 1'b1; i++) @(posedge core_clk);
    wr(8'h00, d);
  endtask
  // hold both lines at a level
  task automatic lines(input logic v);
    @(posedge core_clk);
    sda_level <= v;
    scl_level <= v;
  endtask
  // start plus data byte seen on the bus
  task automatic send_msg();
    @(posedge core_clk);
    host_msg_seen <= 1'b1;
    repeat (4) @(posedge core_clk);
    host_msg_seen <= 1'b0;
  endtask
endmodule // hpsc_host

// file: hdl/hpsc_ctrl.sv
// Operation
// - any state goes to reset on rail loss or while shipping hold is high
// - in reset all converters off, rail fed from source, storage idle
// - leave reset after cold start, sample config pins, go to probe
// - shipping hold high at cold start keeps reset; pin polled each period
// - probe measures storage, samples serial lines, no converter, lasts 2 ms
// - probe ends in start above overdischarge, else deep discharge
// - both serial lines low in probe disables serial port, notify held low
// - host traffic re-enables serial port, raises notify and ready flag
// - start charges storage, rail fed from storage, buck off
// - start goes supply on charge ready or aux charging, deep below overdischarge
// - buck and load status need user enable, storage level, discharge temp
// - supply goes sleep at overcharge or sleep condition
// - qualified low storage in supply moves to deep at window end, no cancel
// - deep discharge charges storage, rail from source, buck off
// - deep goes start above overdischarge, reset on rail loss with storage isolated
// - sleep condition: temperature out, all boosts off, or source low
// - supply condition: temperature ok, a boost on, target above source low
// - sleep: no source charging, rail from storage, aux allowed below overcharge, buck allowed
// - sleep returns to supply on supply condition below overcharge or low storage
// - config pins sampled after cold start and each poll; floating reads high
// - status registers stay valid; monitoring stops updating in pin mode
// - after apply bit only shipping pin is used; notify low in reset
// - notify rises on enabled event, cleared by reading the flag register
// - registers lost on rail loss, kept regardless of io reference supply
`timescale 1ns/1ps
module hpsc_ctrl
  import hpsc_pkg::*;
#(
  parameter int PROBE_CYCLES = PROBE_CYC,
  parameter int POLL_CYCLES = POLL_CYC,
  parameter int QUAL_CYCLES = QUAL_CYC,
  parameter int CRIT_CYCLES = CRIT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // analog comparator results
  input wire logic internal_supply_rail_ok,
  input wire logic internal_supply_rail_cold_ok,
  input wire logic sto_gt_ovdis,
  input wire logic sto_gt_chrdy,
  input wire logic sto_ge_ovch,
  input wire logic sto_gt_buck_ovdis,
  input wire logic sto_gt_buck_rdy,
  input wire logic aux_charging,
  input wire logic temp_in_range,
  input wire logic temp_dis_ok,
  input wire logic src_above_low,
  input wire logic mpp_above_low,
  // pins
  input wire logic shipping_hold_pin,
  input wire logic sda_level,
  input wire logic scl_level,
  input wire logic host_msg_seen,
  input wire logic [CFG_W-1:0] cfg_pins,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // power control
  output logic [2:0] op_state,
  output logic boost_en,
  output logic aux_charge_allow,
  output logic buck_en,
  output logic load_status_pin,
  output logic internal_supply_rail_from_sto,
  output logic battery_node_hiz,
  // host side status
  output logic i2c_enabled,
  output logic notify_pin,
  output logic reg_config_mode,
  output logic monitor_update_en,
  output logic [CFG_W-1:0] cfg_sampled
);

  localparam int SW = SY_N + CFG_W;

  typedef struct packed {
    hpsc_state_e st;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] poll;
    logic [CNT_W-1:0] qual;
    logic [CNT_W-1:0] crit;
    logic sched;
    logic ship;
    logic [CFG_W-1:0] cfg;
    logic i2c_en;
    logic flag;
    logic notify;
    logic [3:0] ctrl;
    logic [7:0] rdata;
  } hpsc_state_s;

  hpsc_state_s s_ff;
  hpsc_state_s nxt_s;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] y;
  logic poll_tick;
  logic crit_end;
  logic reg_mode;
  logic bst_any;
  logic sleep_c;
  logic supply_c;
  logic buck_ok;
  logic ready_set;

  // raw levels into the synchroniser
  assign sync_in = {cfg_pins, host_msg_seen, scl_level, sda_level, shipping_hold_pin,
                    mpp_above_low, src_above_low, temp_dis_ok, temp_in_range,
                    aux_charging, sto_gt_buck_rdy, sto_gt_buck_ovdis, sto_ge_ovch,
                    sto_gt_chrdy, sto_gt_ovdis, internal_supply_rail_cold_ok, internal_supply_rail_ok};
  assign y = s_ff.sync2;

  // derived conditions
  assign poll_tick = s_ff.poll == CNT_W'(POLL_CYCLES - 1);
  assign crit_end = s_ff.crit == CNT_W'(CRIT_CYCLES - 1);
  assign reg_mode = s_ff.ctrl[CTRL_APPLY];
  assign bst_any = reg_mode ? (s_ff.ctrl[CTRL_BST_LSB+:2] != 2'h0) : 1'b1;
  assign sleep_c = !y[SY_TEMP] || !bst_any || !y[SY_SRCLOW];
  assign supply_c = y[SY_TEMP] && bst_any && y[SY_MPP];
  assign buck_ok = (reg_mode ? s_ff.ctrl[CTRL_BUCK] : (s_ff.cfg[CFG_LOAD_LSB+:3] != 3'h0))
                   && (y[SY_CHG] ? y[SY_BOVD] : y[SY_BRDY]) && y[SY_TDIS];

  // next state
  always_comb begin
    nxt_s = s_ff;
    ready_set = 1'b0;
    nxt_s.sync1 = sync_in;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.poll = poll_tick ? '0 : s_ff.poll + 1'b1;
    nxt_s.crit = crit_end ? '0 : s_ff.crit + 1'b1;
    if (poll_tick) begin
      nxt_s.ship = y[SY_SHIP];
      if (!reg_mode) begin
        nxt_s.cfg = y[SY_N+:CFG_W];
      end
    end
    case (s_ff.st)
      ST_RESET: begin
        nxt_s.tmr = '0;
        nxt_s.i2c_en = 1'b0;
        if (y[SY_COLD] && !s_ff.ship) begin
          nxt_s.st = ST_PROBE;
          if (!reg_mode) begin
            nxt_s.cfg = y[SY_N+:CFG_W];
          end
        end
      end
      ST_PROBE: begin
        nxt_s.tmr = s_ff.tmr + 1'b1;
        if (s_ff.tmr == CNT_W'(PROBE_CYCLES - 1)) begin
          nxt_s.st = y[SY_OVDIS] ? ST_START : ST_DEEP;
          nxt_s.i2c_en = y[SY_SDA] || y[SY_SCL];
          ready_set = y[SY_SDA] || y[SY_SCL];
        end
      end
      ST_START: begin
        if (y[SY_CHRDY] || y[SY_CHG]) begin
          nxt_s.st = ST_SUPPLY;
        end else if (!y[SY_OVDIS]) begin
          nxt_s.st = ST_DEEP;
        end
      end
      ST_SUPPLY: begin
        if (!y[SY_OVDIS] && !s_ff.sched) begin
          if (s_ff.qual == CNT_W'(QUAL_CYCLES - 1)) begin
            nxt_s.sched = 1'b1;
          end else begin
            nxt_s.qual = s_ff.qual + 1'b1;
          end
        end else if (!s_ff.sched) begin
          nxt_s.qual = '0;
        end
        if (s_ff.sched && crit_end) begin
          nxt_s.st = ST_DEEP;
        end else if (y[SY_OVCH] || sleep_c) begin
          nxt_s.st = ST_SLEEP;
        end
      end
      ST_DEEP: begin
        if (y[SY_OVDIS]) begin
          nxt_s.st = ST_START;
        end
      end
      ST_SLEEP: begin
        if ((supply_c && !y[SY_OVCH]) || !y[SY_OVDIS]) begin
          nxt_s.st = ST_SUPPLY;
        end
      end
      default: nxt_s.st = ST_RESET;
    endcase
    if (nxt_s.st != ST_SUPPLY) begin
      nxt_s.sched = 1'b0;
      nxt_s.qual = '0;
    end
    // host traffic wakes a disabled serial port
    if (!s_ff.i2c_en && s_ff.st != ST_RESET && s_ff.st != ST_PROBE && y[SY_MSG]) begin
      nxt_s.i2c_en = 1'b1;
      ready_set = 1'b1;
    end
    // register access
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      nxt_s.ctrl = reg_wdata[3:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: nxt_s.rdata = {4'h0, s_ff.ctrl};
        ADDR_EVT: nxt_s.rdata = {7'h00, s_ff.flag};
        ADDR_STATUS: nxt_s.rdata = {3'h0, s_ff.i2c_en, s_ff.sched, s_ff.st};
        default: nxt_s.rdata = 8'h00;
      endcase
      if (reg_addr == ADDR_EVT) begin
        nxt_s.flag = 1'b0;
      end
    end
    if (ready_set) begin
      nxt_s.flag = 1'b1; // set wins over read clear
    end
    // rail loss or shipping hold forces reset
    if (!y[SY_INTERNAL_SUPPLY_RAIL_OK] || s_ff.ship) begin
      nxt_s.st = ST_RESET;
      nxt_s.sched = 1'b0;
      nxt_s.qual = '0;
      nxt_s.i2c_en = 1'b0;
      nxt_s.flag = 1'b0;
    end
    if (!y[SY_INTERNAL_SUPPLY_RAIL_OK]) begin
      nxt_s.ctrl = CTRL_RESET;
    end
    nxt_s.notify = nxt_s.flag && nxt_s.i2c_en && nxt_s.st != ST_RESET;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{st: ST_RESET, ctrl: CTRL_RESET, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // converter and supply selection per state
  assign op_state = s_ff.st;
  assign boost_en = (s_ff.st == ST_START || s_ff.st == ST_SUPPLY || s_ff.st == ST_DEEP)
                    && bst_any && !y[SY_CHG];
  assign aux_charge_allow = s_ff.st == ST_START || s_ff.st == ST_SUPPLY
                            || s_ff.st == ST_DEEP
                            || (s_ff.st == ST_SLEEP && !y[SY_OVCH]);
  assign buck_en = (s_ff.st == ST_SUPPLY || s_ff.st == ST_SLEEP) && buck_ok;
  assign load_status_pin = buck_en;
  assign internal_supply_rail_from_sto = s_ff.st == ST_START || s_ff.st == ST_SUPPLY
                         || s_ff.st == ST_SLEEP;
  assign battery_node_hiz = s_ff.st == ST_RESET;
  assign i2c_enabled = s_ff.i2c_en;
  assign notify_pin = s_ff.notify;
  assign reg_config_mode = reg_mode;
  assign monitor_update_en = reg_mode && s_ff.st != ST_RESET;
  assign cfg_sampled = s_ff.cfg;
  assign reg_rdata = s_ff.rdata;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence rst_cause_q;
    !y[SY_INTERNAL_SUPPLY_RAIL_OK] || s_ff.ship;
  endsequence
  sequence probe_exit_q;
    s_ff.st == ST_PROBE ##1 s_ff.st != ST_PROBE && s_ff.st != ST_RESET;
  endsequence

  reset_entry_a: assert property (rst_cause_q |=> s_ff.st == ST_RESET)
    else $error("reset cause did not force reset");
  reset_off_a: assert property (s_ff.st == ST_RESET |-> !boost_en && !buck_en
    && !internal_supply_rail_from_sto && battery_node_hiz) else $error("converter active in reset");
  leave_reset_a: assert property ($past(s_ff.st == ST_RESET) && s_ff.st != ST_RESET
    |-> s_ff.st == ST_PROBE && $past(y[SY_COLD]) && !$past(s_ff.ship))
    else $error("bad exit from reset");
  probe_len_a: assert property (probe_exit_q
    |-> $past(s_ff.tmr) == CNT_W'(PROBE_CYCLES - 1)) else $error("probe length wrong");
  probe_dest_a: assert property (probe_exit_q |-> (s_ff.st == ST_START)
    == $past(y[SY_OVDIS])) else $error("probe exit target wrong");
  serial_off_a: assert property (probe_exit_q |-> i2c_enabled
    == $past(y[SY_SDA] || y[SY_SCL])) else $error("serial enable decision wrong");
  wake_serial_a: assert property (!i2c_enabled && s_ff.st inside {ST_START, ST_SUPPLY}
    && y[SY_MSG] && y[SY_INTERNAL_SUPPLY_RAIL_OK] && !s_ff.ship && !reg_rd |=> i2c_enabled && notify_pin)
    else $error("host traffic did not wake serial port");
  buck_gate_a: assert property (buck_en |-> y[SY_TDIS]
    && s_ff.st inside {ST_SUPPLY, ST_SLEEP}) else $error("buck on outside its conditions");
  crit_move_a: assert property (s_ff.st == ST_SUPPLY && s_ff.sched && crit_end
    && y[SY_INTERNAL_SUPPLY_RAIL_OK] && !s_ff.ship |=> s_ff.st == ST_DEEP) else $error("no deep move");
  notify_low_a: assert property (s_ff.st == ST_RESET |-> !notify_pin)
    else $error("notify high in reset");

endmodule // hpsc_ctrl

// file: hdl/hpsc_pkg.sv
package hpsc_pkg;
  // clock and timing (times in ns)
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROBE_NS = 2000000;
  localparam int PROBE_CYC = PROBE_NS / CLK_PERIOD_NS;
  localparam int POLL_NS = 1000000;
  localparam int POLL_CYC = POLL_NS / CLK_PERIOD_NS;
  localparam int QUAL_NS = 500000;
  localparam int QUAL_CYC = QUAL_NS / CLK_PERIOD_NS;
  localparam int CRIT_NS = 2000000;
  localparam int CRIT_CYC = CRIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int CFG_W = 8;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EVT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h19;
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_BUCK = 1;
  localparam int CTRL_BST_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'he;
  localparam int EVT_READY = 0;
  localparam int CFG_LOAD_LSB = 0;
  // synchroniser bit positions
  localparam int SY_INTERNAL_SUPPLY_RAIL_OK = 0;
  localparam int SY_COLD = 1;
  localparam int SY_OVDIS = 2;
  localparam int SY_CHRDY = 3;
  localparam int SY_OVCH = 4;
  localparam int SY_BOVD = 5;
  localparam int SY_BRDY = 6;
  localparam int SY_CHG = 7;
  localparam int SY_TEMP = 8;
  localparam int SY_TDIS = 9;
  localparam int SY_SRCLOW = 10;
  localparam int SY_MPP = 11;
  localparam int SY_SHIP = 12;
  localparam int SY_SDA = 13;
  localparam int SY_SCL = 14;
  localparam int SY_MSG = 15;
  localparam int SY_N = 16;
  typedef enum logic [2:0] {
    ST_RESET, ST_PROBE, ST_START, ST_SUPPLY, ST_DEEP, ST_SLEEP
  } hpsc_state_e;
endpackage
